// *** core/column_driver.sv ***
`timescale 1ns/10ps
`default_nettype none

module column_driver #(
    parameter int CHAIN = column_driver_pkg::CHAIN_BITS,
    parameter int DEPTH = column_driver_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // controller pins
    input  wire logic                 column_shift_clock,
    input  wire logic                 row_latch_pulse,
    input  wire logic                 frame_polarity,
    input  wire logic                 lower_serial_in,
    input  wire logic                 upper_serial_in,
    // cascade outputs
    output logic                      lower_serial_out,
    output logic                      upper_serial_out,
    // column drive, two bits per column
    output logic [2*2*CHAIN-1:0]      column_drive_outputs,
    // back-pressure status
    output logic                      sample_overflow
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] sync_a;
    logic [4:0] sync_b;

    // two flops per pin; logic reads only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= {column_shift_clock, row_latch_pulse, frame_polarity,
                       lower_serial_in, upper_serial_in};
            sync_b <= sync_a;
        end
    end

    logic shift_sync;
    logic latch_sync;
    logic frame_sync;
    logic lower_sync;
    logic upper_sync;

    assign shift_sync = sync_b[4];
    assign latch_sync = sync_b[3];
    assign frame_sync = sync_b[2];
    assign lower_sync = sync_b[1];
    assign upper_sync = sync_b[0];

    // ****************************************
    // falling edge detection
    // ****************************************
    logic shift_prev;
    logic latch_prev;
    logic shift_fall;
    logic latch_fall;

    function automatic logic fell(input logic prev, input logic cur);
        fell = prev && !cur;
    endfunction

    // history resets low: a pin idling high at release shows no false fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_prev <= 1'b0;
            latch_prev <= 1'b0;
        end else begin
            shift_prev <= shift_sync;
            latch_prev <= latch_sync;
        end
    end

    assign shift_fall = fell(shift_prev, shift_sync);
    assign latch_fall = fell(latch_prev, latch_sync);

    // ****************************************
    // sample buffer
    // ****************************************
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [1:0] fifo_out_data;

    // data sampled at the falling edge, queued toward the chains
    column_fifo #(
        .WIDTH (column_driver_pkg::FIFO_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (shift_fall),
        .in_ready  (fifo_in_ready),
        .in_data   ({lower_sync, upper_sync}),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample_overflow <= 1'b0;
        end else if (shift_fall && !fifo_in_ready) begin
            sample_overflow <= 1'b1;
        end
    end

    // ****************************************
    // shift chains
    // ****************************************
    logic [CHAIN-1:0] lower_chain;
    logic [CHAIN-1:0] upper_chain;

    // new bit enters the bottom stage and moves up one column per edge
    function automatic logic [CHAIN-1:0] shift_in(input logic [CHAIN-1:0] c,
                                                  input logic b);
        shift_in = {c[CHAIN-2:0], b};
    endfunction

    // lower chain, columns 0 to 31
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lower_chain <= CHAIN'(column_driver_pkg::CHAIN_RESET);
        end else if (fifo_out_valid) begin
            lower_chain <= shift_in(lower_chain, fifo_out_data[1]);
        end
    end

    // upper chain, columns 32 to 63
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upper_chain <= CHAIN'(column_driver_pkg::CHAIN_RESET);
        end else if (fifo_out_valid) begin
            upper_chain <= shift_in(upper_chain, fifo_out_data[0]);
        end
    end

    // leaving bit sits in the top stage of each chain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lower_serial_out <= 1'b0;
        end else begin
            lower_serial_out <= lower_chain[CHAIN-1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upper_serial_out <= 1'b0;
        end else begin
            upper_serial_out <= upper_chain[CHAIN-1];
        end
    end

    // ****************************************
    // row latch
    // ****************************************
    logic [2*CHAIN-1:0] row_latch;
    logic               latch_pending;

    // latch waits until queued samples have reached the chains
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_pending <= 1'b0;
        end else if (latch_fall) begin
            latch_pending <= 1'b1;
        end else if (!fifo_out_valid) begin
            latch_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            row_latch <= column_driver_pkg::LATCH_RESET;
        end else if (latch_pending && !fifo_out_valid) begin
            row_latch <= {upper_chain, lower_chain};
        end
    end

    // ****************************************
    // drive level selection
    // ****************************************
    function automatic logic [1:0] pick_level(input logic bit_on, input logic frame);
        if (bit_on && !frame) begin
            pick_level = column_driver_pkg::level_top_rail;
        end else if (bit_on) begin
            pick_level = column_driver_pkg::level_high_voltage;
        end else if (!frame) begin
            pick_level = column_driver_pkg::level_off_frame_low;
        end else begin
            pick_level = column_driver_pkg::level_off_frame_high;
        end
    endfunction

    // frame reaches the outputs three clocks after its pin moves
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            column_drive_outputs <= '0;
        end else begin
            for (int i = 0; i < 2*CHAIN; i++) begin
                column_drive_outputs[2*i +: 2] <= pick_level(row_latch[i], frame_sync);
            end
        end
    end

endmodule

`default_nettype wire

// *** core/column_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none

module column_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// *** inc/column_driver_pkg.sv ***
`default_nettype none

package column_driver_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int CHAIN_BITS   = 32;
    localparam int COLUMN_COUNT = 64;
    localparam int FIFO_DEPTH   = 16;
    localparam int FIFO_WIDTH   = 2;

    // ****************************************
    // drive level encoding
    // ****************************************
    typedef enum logic [1:0] {
        level_top_rail,
        level_high_voltage,
        level_off_frame_low,
        level_off_frame_high
    } drive_level_t;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] CHAIN_RESET = 32'h0000_0000;
    localparam logic [63:0] LATCH_RESET = 64'h0000_0000_0000_0000;

endpackage

`default_nettype wire

// *** verif/column_controller_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module column_controller_model (
    // clock
    input  wire logic clk,
    // pins toward the driver
    output logic      column_shift_clock,
    output logic      row_latch_pulse,
    output logic      lower_serial_in,
    output logic      upper_serial_in
);
    initial begin
        column_shift_clock = 1'b1;
        row_latch_pulse = 1'b1;
        lower_serial_in = 1'b0;
        upper_serial_in = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // highest column first, gap stretches the idle high time
    task automatic shift_row(input logic [63:0] row, input int gap);
        for (int i = 0; i < 32; i++) begin
            lower_serial_in <= row[31-i];
            upper_serial_in <= row[63-i];
            step(2 + gap);
            column_shift_clock <= 1'b0;
            step(6);
            column_shift_clock <= 1'b1;
            lower_serial_in <= !row[31-i];
            upper_serial_in <= !row[63-i];
            step(1);
        end
    endtask
    task automatic latch_row();
        step(2);
        row_latch_pulse <= 1'b0;
        step(6);
        row_latch_pulse <= 1'b1;
        step(8);
    endtask
endmodule

`default_nettype wire

// *** verif/column_driver_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

module column_driver_sva #(
    parameter int CHAIN = column_driver_pkg::CHAIN_BITS
) (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // controller pins
    input wire logic                 column_shift_clock,
    input wire logic                 row_latch_pulse,
    input wire logic                 frame_polarity,
    // outputs
    input wire logic                 lower_serial_out,
    input wire logic                 upper_serial_out,
    input wire logic [2*2*CHAIN-1:0] column_drive_outputs,
    input wire logic                 sample_overflow
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence shift_idle;
        column_shift_clock [*8];
    endsequence
    sequence drive_idle;
        (row_latch_pulse && $stable(frame_polarity)) [*8];
    endsequence
    a_lower_hold: assert property (shift_idle |-> $stable(lower_serial_out))
        else $error("lower serial out moved while idle");
    a_upper_hold: assert property (shift_idle |-> $stable(upper_serial_out))
        else $error("upper serial out moved while idle");
    a_lower_move: assert property ($changed(lower_serial_out) |-> !$past(column_shift_clock, 4))
        else $error("lower serial out moved without shift");
    a_upper_move: assert property ($changed(upper_serial_out) |-> !$past(column_shift_clock, 4))
        else $error("upper serial out moved without shift");
    a_frame_code: assert property ($stable(frame_polarity) [*6] |->
        (column_drive_outputs & {2*CHAIN{2'b01}}) == {2*CHAIN{1'b0, frame_polarity}})
        else $error("drive code does not follow frame");
    a_drive_hold: assert property (drive_idle |-> $stable(column_drive_outputs))
        else $error("drive moved between latches");
    a_drive_cause: assert property ($changed(column_drive_outputs) |-> !$past(row_latch_pulse, 4)
        || frame_polarity != $past(frame_polarity, 6) || $past(rst, 6))
        else $error("drive moved without latch or frame");
    a_no_overflow: assert property (!sample_overflow)
        else $error("shift sample lost");
endmodule

bind column_driver column_driver_sva #(.CHAIN(CHAIN)) i_column_driver_sva (
    .clk(clk), .rst(rst), .column_shift_clock(column_shift_clock),
    .row_latch_pulse(row_latch_pulse), .frame_polarity(frame_polarity),
    .lower_serial_out(lower_serial_out), .upper_serial_out(upper_serial_out),
    .column_drive_outputs(column_drive_outputs), .sample_overflow(sample_overflow)
);

`default_nettype wire

// *** verif/tb_lcd_column_shift_latch_driver.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_lcd_column_shift_latch_driver;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         frame = 1'b0;
    logic         sck, lp, din_lo, din_hi, dout_lo, dout_hi, ovf;
    logic [127:0] drive;
    logic [63:0]  shown = 64'h0;
    int           fails = 0;
    int           n_compared = 0;

    always #10 clk = !clk;

    column_driver i_column_driver (
        .clk(clk), .rst(rst), .column_shift_clock(sck), .row_latch_pulse(lp),
        .frame_polarity(frame), .lower_serial_in(din_lo), .upper_serial_in(din_hi),
        .lower_serial_out(dout_lo), .upper_serial_out(dout_hi),
        .column_drive_outputs(drive), .sample_overflow(ovf)
    );
    column_controller_model i_column_controller_model (
        .clk(clk), .column_shift_clock(sck), .row_latch_pulse(lp),
        .lower_serial_in(din_lo), .upper_serial_in(din_hi)
    );

    function automatic logic [127:0] exp_drive(input logic [63:0] row, input logic fr);
        for (int i = 0; i < 64; i++)
            exp_drive[2*i +: 2] = {!row[i], fr};
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("BAD %0t saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_reset();
        check(drive, 128'h0);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        check(drive, exp_drive(64'h0, frame));
    endtask
    task automatic t_row(input logic [63:0] row, input int gap);
        i_column_controller_model.shift_row(row, gap);
        check(dout_lo, row[31]);
        check(dout_hi, row[63]);
        check(drive, exp_drive(shown, frame));
        i_column_controller_model.latch_row();
        shown = row;
        check(drive, exp_drive(row, frame));
        check(ovf, 1'b0);
    endtask
    task automatic t_frame();
        frame <= !frame;
        repeat (8) @(posedge clk);
        check(drive, exp_drive(shown, frame));
    endtask

    initial begin
        repeat (16) @(posedge clk);
        t_reset();
        t_row(64'h8000_0001_c3a5_0ff0, 0);
        t_frame();
        t_row(64'h7ffe_0002_5a3c_f00f, 30);
        t_frame();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule

`default_nettype wire
